//--- rtl/nsx_exec.sv
// Execution datapath for nibble swap and subtract-with-borrow
// Assumes decoded instruction words arrive from logic on the same clock
`timescale 1ns/10ps

// Operation
// [RL1] Swap writes file bits 3:0 to result 7:4 and 7:4 to 3:0
// [RL2] Destination bit 0 sends result to working register, file untouched
// [RL3] Destination bit 1 writes result back to the addressed file register
// [RL4] Bank-access bit 0 uses the access bank, ignoring bank select
// [RL5] Bank-access bit 1 forms address from the bank select register
// [RL6] Subtract computes file minus working minus inverted carry, two's complement
// [RL7] Swap leaves status flags unchanged and takes one four-phase cycle
module nsx_exec (
    input wire logic clk,
    input wire logic rst,
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    input wire logic [nsx_pkg::BANK_W-1:0] bank_select_register,
    input wire logic carry_in,
    output logic [nsx_pkg::DATA_W-1:0] working_register,
    output logic busy,
    output logic done,
    output logic illegal,
    output logic carry_out,
    output logic digit_carry,
    output logic zero,
    output logic negative,
    output logic overflow,
    output logic flags_we,
    output logic file_we,
    output logic [nsx_pkg::ADDR_W-1:0] file_addr,
    output logic [nsx_pkg::DATA_W-1:0] file_wdata
);
    import nsx_pkg::*;

    // ----------------------------------------
    // Phase sequencer
    // ----------------------------------------
    nsx_phase_e phase_r;
    logic [15:0] instr_r;
    logic [DATA_W-1:0] operand;
    logic [DATA_W-1:0] result_r;
    logic [ADDR_W-1:0] addr_r;
    logic [ADDR_W-1:0] addr_nxt;
    logic is_swap;
    logic is_subb;
    logic dest_file;
    logic [DATA_W:0] diff;
    logic [4:0] low_diff;
    logic borrow_in;
    logic c_r;
    logic dc_r;
    logic ov_r;

    assign is_swap = instr_r[OPC_MSB:OPC_LSB] == OPC_SWAP;
    assign is_subb = instr_r[OPC_MSB:OPC_LSB] == OPC_SUBB;
    assign dest_file = instr_r[DEST_BIT];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_r <= NSX_Q1;
        end else begin
            unique case (phase_r)
                NSX_Q1: begin
                    if (instr_valid) begin
                        phase_r <= NSX_Q2;
                    end
                end
                NSX_Q2: begin
                    phase_r <= NSX_Q3;
                end
                NSX_Q3: begin
                    phase_r <= NSX_Q4;
                end
                NSX_Q4: begin
                    phase_r <= NSX_Q1; // RL7
                end
            endcase
        end
    end

    // ----------------------------------------
    // Decode and address formation
    // ----------------------------------------
    always_comb begin
        if (instr[ACC_BIT]) begin
            addr_nxt = {bank_select_register, instr[FILE_MSB:FILE_LSB]}; // RL5
        end else if (instr[FILE_MSB:FILE_LSB] < ACC_SPLIT) begin
            addr_nxt = {ACC_LOW_BANK, instr[FILE_MSB:FILE_LSB]}; // RL4
        end else begin
            addr_nxt = {ACC_HIGH_BANK, instr[FILE_MSB:FILE_LSB]}; // RL4
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            instr_r <= 16'h0000;
            addr_r <= ADDR_RST;
        end else if (phase_r == NSX_Q1 && instr_valid) begin
            instr_r <= instr;
            addr_r <= addr_nxt;
        end
    end

    // ----------------------------------------
    // Operand memory
    // ----------------------------------------
    logic ram_we;
    assign ram_we = phase_r == NSX_Q4 && dest_file && (is_swap || is_subb);

    nsx_file_ram #(
        .AW(ADDR_W),
        .DW(DATA_W)
    ) u_ram (
        .clk(clk),
        .wr_en(ram_we),
        .wr_addr(addr_r),
        .wr_data(result_r),
        .rd_addr(addr_r),
        .rd_data(operand)
    );

    // ----------------------------------------
    // Process data (Q3)
    // ----------------------------------------
    assign borrow_in = ~carry_in;
    assign diff = {1'b0, operand} - {1'b0, working_register} - {8'h00, borrow_in}; // RL6
    assign low_diff = {1'b0, operand[3:0]} - {1'b0, working_register[3:0]}
                      - {4'h0, borrow_in};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            result_r <= DATA_RST;
        end else if (phase_r == NSX_Q3) begin
            if (is_swap) begin
                result_r <= {operand[3:0], operand[7:4]}; // RL1
            end else begin
                result_r <= diff[DATA_W-1:0]; // RL6
            end
        end
    end

    // Subtract flags staged beside the result
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            c_r <= 1'b0;
            dc_r <= 1'b0;
            ov_r <= 1'b0;
        end else if (phase_r == NSX_Q3) begin
            c_r <= ~diff[DATA_W]; // RL6
            dc_r <= ~low_diff[4];
            ov_r <= (operand[7] != working_register[7]) && (diff[7] != operand[7]);
        end
    end

    // ----------------------------------------
    // Write to destination (Q4)
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            working_register <= WORK_RST;
        end else if (phase_r == NSX_Q4 && !dest_file && (is_swap || is_subb)) begin
            working_register <= result_r; // RL2
        end
    end

    // ----------------------------------------
    // File write mirror and completion strobes
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            file_we <= 1'b0;
            file_addr <= ADDR_RST;
            file_wdata <= DATA_RST;
        end else begin
            file_we <= ram_we; // RL3
            file_addr <= addr_r;
            file_wdata <= result_r;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done <= 1'b0;
            illegal <= 1'b0;
        end else begin
            done <= phase_r == NSX_Q4; // RL7
            illegal <= phase_r == NSX_Q4 && !(is_swap || is_subb);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags_we <= 1'b0;
        end else begin
            flags_we <= phase_r == NSX_Q4 && is_subb; // RL7
        end
    end

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            carry_out <= 1'b0;
            digit_carry <= 1'b0;
            zero <= 1'b0;
            negative <= 1'b0;
            overflow <= 1'b0;
        end else if (phase_r == NSX_Q4 && is_subb) begin
            carry_out <= c_r; // RL6
            digit_carry <= dc_r;
            zero <= result_r == 8'h00;
            negative <= result_r[7];
            overflow <= ov_r;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
        end else begin
            busy <= (phase_r == NSX_Q1 && instr_valid) || phase_r == NSX_Q2
                    || phase_r == NSX_Q3;
        end
    end
endmodule // nsx_exec

//--- rtl/nsx_pkg.sv
// Package for the nibble-swap / subtract-with-borrow execution datapath
// Assumes a single instruction clock domain, four phases per instruction
package nsx_pkg;

    localparam int DATA_W = 8;
    localparam int FADDR_W = 8;
    localparam int BANK_W = 4;
    localparam int ADDR_W = 12;

    // Instruction word layout: oooo oo d a ffff ffff
    localparam int OPC_MSB = 15;
    localparam int OPC_LSB = 10;
    localparam int DEST_BIT = 9;
    localparam int ACC_BIT = 8;
    localparam int FILE_MSB = 7;
    localparam int FILE_LSB = 0;
    localparam logic [5:0] OPC_SWAP = 6'h0e;
    localparam logic [5:0] OPC_SUBB = 6'h16;

    // Access bank: low half maps to bank 0, high half to the top bank
    localparam logic [FADDR_W-1:0] ACC_SPLIT = 8'h80;
    localparam logic [BANK_W-1:0] ACC_LOW_BANK = 4'h0;
    localparam logic [BANK_W-1:0] ACC_HIGH_BANK = 4'hf;

    localparam logic [DATA_W-1:0] WORK_RST = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

    typedef enum logic [1:0] {
        NSX_Q1,
        NSX_Q2,
        NSX_Q3,
        NSX_Q4
    } nsx_phase_e;

endpackage

//--- rtl/nsx_file_ram.sv
// File register memory with registered read data
// Assumes write and read in the same clock domain
`timescale 1ns/10ps
module nsx_file_ram #(
    parameter int AW = 12,
    parameter int DW = 8
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);
    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // nsx_file_ram

//--- verif/nsx_exec_asserts.sv
// Checker on the exec datapath control and status outputs
// Assumes one clock, reset asynchronous active high
`timescale 1ns/10ps
module nsx_exec_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic busy,
    input wire logic done,
    input wire logic illegal,
    input wire logic carry_out,
    input wire logic digit_carry,
    input wire logic zero,
    input wire logic negative,
    input wire logic overflow,
    input wire logic flags_we,
    input wire logic file_we,
    input wire logic [nsx_pkg::DATA_W-1:0] working_register
);
    import nsx_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire [4:0] flags = {carry_out, digit_carry, zero, negative, overflow};
    AST_FWE_DONE: assert property (file_we |-> done && !illegal)
        else $error("file write outside done");
    AST_FLAGS_SUB: assert property (flags_we |-> done && !illegal)
        else $error("flag write outside done");
    AST_ILL_QUIET: assert property (illegal |-> done && !file_we && !flags_we)
        else $error("refused op wrote");
    AST_DONE_GAP: assert property (done |=> !done [*3])
        else $error("done too close");
    AST_DONE_BUSY: assert property (done |-> $past(busy))
        else $error("done without busy");
    AST_FLAGS_HOLD: assert property (!flags_we |-> $stable(flags))
        else $error("flags moved");
    AST_WORKING_REGISTER_HOLD: assert property (!done || file_we || illegal |-> $stable(working_register))
        else $error("working register moved");
    AST_RST_IDLE: assert property ($fell(rst) |-> !busy && !done && !file_we)
        else $error("not idle after reset");
    cover property (file_we);
    cover property (flags_we && !file_we);
    cover property (illegal);
endmodule // nsx_exec_chk

bind nsx_exec nsx_exec_chk u_nsx_exec_chk (.*);

//--- verif/nibble_swap_subtract_borrow_exec_tb.sv
// Bench for the exec datapath: corner and random instructions
// Assumes the bench preloads file memory through the hierarchy and mirrors it
`timescale 1ns/10ps
module nibble_swap_subtract_borrow_exec_tb;
    import nsx_pkg::*;
    logic clk = 0, rst = 1, instr_valid = 0, carry_in = 0;
    logic [15:0] instr = 16'h0000;
    logic [3:0] bank_select_register = 4'h0;
    logic [7:0] working_register, file_wdata;
    logic busy, done, illegal, carry_out, digit_carry, zero, negative, overflow;
    logic flags_we, file_we;
    logic [11:0] file_addr;
    int n_errors = 0, checks_done = 0;
    logic [7:0] w_exp = 8'h00;
    logic [4:0] fl_exp = 5'h00;
    logic [7:0] fmem [4096];
    nsx_exec u_nsx_exec (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
        .bank_select_register(bank_select_register), .carry_in(carry_in),
        .working_register(working_register), .busy(busy), .done(done), .illegal(illegal),
        .carry_out(carry_out), .digit_carry(digit_carry), .zero(zero), .negative(negative),
        .overflow(overflow), .flags_we(flags_we), .file_we(file_we), .file_addr(file_addr),
        .file_wdata(file_wdata));
    initial forever #12.5 clk = ~clk;
    function automatic logic [11:0] exp_addr(logic a, logic [3:0] b, logic [7:0] f);
        if (a) return {b, f};
        return {(f < ACC_SPLIT) ? ACC_LOW_BANK : ACC_HIGH_BANK, f};
    endfunction
    function automatic logic [4:0] sub_flags(logic [7:0] v, logic [7:0] w, logic c);
        int u;
        int sg;
        u = int'(v) - int'(w) - int'(!c);
        sg = int'($signed(v)) - int'($signed(w)) - int'(!c);
        return {u >= 0, int'(v[3:0]) - int'(w[3:0]) - int'(!c) >= 0, 8'(u) == 8'h00,
                u[7], sg < -128 || sg > 127};
    endfunction
    task automatic put(logic [11:0] ad, logic [7:0] v);
        fmem[ad] = v;
        u_nsx_exec.u_ram.mem[ad] = v;
    endtask
    task automatic cmp(logic [11:0] got, logic [11:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        if (n_errors == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic run(logic [5:0] op, logic d, logic a, logic [7:0] f, logic [3:0] b, int k,
                       logic c);
        logic [11:0] ad;
        logic [7:0] v;
        logic [7:0] res;
        logic ok;
        int n;
        ad = exp_addr(a, b, f);
        v = fmem[ad];
        ok = (op == OPC_SWAP) || (op == OPC_SUBB);
        n = k;
        res = (op == OPC_SWAP) ? {v[3:0], v[7:4]} : 8'(int'(v) - int'(w_exp) - int'(!c));
        if (op == OPC_SUBB) fl_exp = sub_flags(v, w_exp, c);
        @(posedge clk);
        instr_valid <= 1;
        instr <= {op, d, a, f};
        bank_select_register <= b;
        carry_in <= c;
        @(posedge clk);
        instr_valid <= (k > 0);
        instr <= {6'h3f, ~d, ~a, ~f};
        bank_select_register <= ~b;
        repeat (k) @(posedge clk);
        instr_valid <= 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (n < 8 && done !== 1'b1);
        cmp(12'(n), 12'h003);
        cmp(12'(illegal), 12'(!ok));
        cmp(12'(file_we), 12'(ok && d));
        cmp(12'(flags_we), 12'(op == OPC_SUBB));
        if (ok && d) cmp(file_addr, ad);
        if (ok && d) cmp(12'(file_wdata), 12'(res));
        if (ok && d) fmem[ad] = res;
        if (ok && !d) w_exp = res;
        cmp(12'({carry_out, digit_carry, zero, negative, overflow}), 12'(fl_exp));
        cmp(12'(working_register), 12'(w_exp));
    endtask
    initial begin
        logic [5:0] op;
        void'($urandom(88));
        for (int i = 0; i < 4096; i++) put(12'(i), 8'($urandom));
        put(12'h020, 8'h53);
        put(12'h021, 8'hd0);
        put(12'h022, 8'h19);
        put(12'h023, 8'ha1);
        put(12'h024, 8'h1b);
        put(12'h025, 8'he0);
        put(12'h026, 8'h03);
        repeat (5) @(posedge clk);
        rst <= 0;
        run(OPC_SWAP, 1, 0, 8'h20, 4'h7, 0, 0);
        cmp(12'(file_wdata), 12'h035);
        run(OPC_SWAP, 0, 0, 8'h21, 4'h7, 1, 0);
        run(OPC_SUBB, 1, 0, 8'h22, 4'h7, 0, 1);
        cmp(12'(file_wdata), 12'h00c);
        run(OPC_SWAP, 0, 0, 8'h23, 4'h7, 2, 1);
        run(OPC_SUBB, 0, 0, 8'h24, 4'h7, 0, 0);
        cmp(12'({working_register, carry_out, zero}), 12'h003);
        run(OPC_SWAP, 0, 0, 8'h25, 4'h7, 0, 1);
        run(OPC_SUBB, 1, 0, 8'h26, 4'h7, 1, 1);
        cmp(12'({file_wdata, carry_out, negative}), 12'h3d5);
        for (int i = 0; i < 4; i++) begin
            run(i[0] ? OPC_SUBB : OPC_SWAP, 1, 0, i[1] ? 8'h80 : 8'h7f, 4'h5, i % 3, i[0]);
        end
        run(OPC_SWAP, 1, 1, 8'hff, 4'hf, 0, 0);
        run(6'h3f, 0, 0, 8'h10, 4'h0, 1, 1);
        for (int i = 0; i < 200; i++) begin
            op = (i % 3 == 0) ? OPC_SWAP : (i % 3 == 1) ? OPC_SUBB : 6'($urandom);
            run(op, 1'($urandom), 1'($urandom), 8'($urandom), 4'($urandom), $urandom_range(2),
                1'($urandom));
        end
        end_sim();
    end
    initial begin
        #100000;
        n_errors++;
        end_sim();
    end
endmodule // nibble_swap_subtract_borrow_exec_tb
